// ### design/clock_generator_unit.sv
// clock generator unit: sources, pll, sixteen derived clocks, sleep gating,
// mii clock gating and monitoring, configured over Avalon-MM
// assumes oscillator and pad clocks are asynchronous and slower than clk/2
// Function
// - external and rc oscillators feed system clock
// - 32.768 kHz source drives calendar clock only
// - pll reference runs 8 to 24 MHz
// - register picks pll reference oscillator
// - pll out is in times m over n over od
// - m and n are six-bit unsigned fields
// - od factor is one, two, four or eight
// - each derived clock picks its own source
// - fast clocks divide by 1 to 8
// - slow clocks divide by 1 to 128
// - two timer and eight pwm clocks exist
// - random clock is raw pll output
// - converter and random clocks stop in sleep
// - mii receive and transmit clocks are gateable
// - every generated clock can be monitored
// - deep sleep also gates bus and memory
`timescale 1ns/100ps
module clock_generator_unit
  import clock_generator_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // oscillator and pad clocks, asynchronous
  input  wire logic        extOscClock,
  input  wire logic        rcOscClock,
  input  wire logic        lowSpeedClock,
  input  wire logic        miiRxPad,
  input  wire logic        miiTxPad,
  // processor sleep state, same domain
  input  wire logic        cpuSleep,
  // generated clocks as one-cycle edge pulses, sleep clock enables as levels
  output logic      [15:0] derivedClock,
  output logic             randomGenClock,
  output logic             miiRxClock,
  output logic             miiTxClock,
  output logic             cpuClockEn,
  output logic             busClockEn,
  output logic             memClockEn,
  output logic             monitorClock
);
  // synchronisers: stage a, stage b, then previous for edge detect
  logic [4:0] syncA;
  logic [4:0] syncB;
  logic [4:0] syncPrev;
  logic [4:0] rise;      // 0 ext, 1 rc, 2 low, 3 rx, 4 tx

  // registers
  logic        refSel;           // 0 rc, 1 external
  logic        bypass;
  logic [5:0]  mult;
  logic [5:0]  div;
  logic [1:0]  odiv;
  logic        deepSleepSelect;
  logic        rxEn;
  logic        txEn;
  logic [MON_WIDTH-1:0]   monSel;
  logic [COUNT_WIDTH-1:0] monCount;
  src_t        cfgSrc [NUM_CLOCKS];
  logic [2:0]  cfgPre [NUM_CLOCKS];

  logic        pllPulse;
  logic        refPulse;
  logic [15:0] divOut;
  logic [22:0] monVec;
  logic        monNow;
  logic        access;
  logic        wrTake;
  logic        cfgHit;
  logic [3:0]  cfgIdx;
  logic [31:0] next_readdata;

  src_pulse_if srcBus ();

  // two flip-flops before any logic reads a pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA    <= 5'h00;
      syncB    <= 5'h00;
      syncPrev <= 5'h00;
    end else begin
      syncA    <= {miiTxPad, miiRxPad, lowSpeedClock, rcOscClock, extOscClock};
      syncB    <= syncA;
      syncPrev <= syncB;
    end
  end
  assign rise = syncB & ~syncPrev;

  // pll reference choice; range 8..24 MHz is the board's duty
  assign refPulse = refSel ? rise[0] : rise[1];

  pll_rate_model pll (
    .clk      (clk),
    .rst_n    (rst_n),
    .refPulse (refPulse),
    .mult     (mult),
    .div      (div),
    .odiv     (odiv),
    .bypass   (bypass),
    .pllPulse (pllPulse)
  );

  // low-speed pulse is offered to every divider but only the calendar
  // clock may store that code
  assign srcBus.pulse = {rise[2], rise[0], pllPulse, rise[1]};

  // sixteen derived clocks: system, converter, two serial, two timers,
  // eight pwm, calendar, watchdog
  for (genvar i = 0; i < NUM_CLOCKS; i++) begin : g_div
    derived_clock_divider dv (
      .clk      (clk),
      .rst_n    (rst_n),
      .src      (srcBus),
      .srcSel   (cfgSrc[i]),
      .preSel   (cfgPre[i]),
      .outPulse (divOut[i])
    );
  end

  // bus decode
  assign access = (read || write) && waitrequest;
  assign wrTake = write && !waitrequest;
  assign cfgHit = address[7:6] == CFG_BASE_OFS[7:6];
  assign cfgIdx = address[5:2];

  function automatic logic [2:0] pre_mask(input logic [3:0] idx);
    pre_mask = (idx < 4'(FAST_CLOCKS)) ? PRE_FAST_MASK : PRE_SLOW_MASK;
  endfunction

  // read mux, unmapped addresses read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (cfgHit) begin
      next_readdata[SRC_LSB +: 2] = cfgSrc[cfgIdx];
      next_readdata[PRE_LSB +: 3] = cfgPre[cfgIdx];
    end else begin
      case (address)
        PLL_CTRL_OFS: begin
          next_readdata[REF_SEL_BIT] = refSel;
          next_readdata[BYPASS_BIT]  = bypass;
        end
        PLL_FACTOR_OFS: begin
          next_readdata[MULT_LSB +: 6] = mult;
          next_readdata[DIV_LSB +: 6]  = div;
          next_readdata[ODIV_LSB +: 2] = odiv;
        end
        POWER_OFS: begin
          next_readdata[DEEP_BIT]  = deepSleepSelect;
          next_readdata[RX_EN_BIT] = rxEn;
          next_readdata[TX_EN_BIT] = txEn;
        end
        MON_SEL_OFS:   next_readdata[MON_WIDTH-1:0]   = monSel;
        MON_COUNT_OFS: next_readdata[COUNT_WIDTH-1:0] = monCount;
        default:       next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // waitrequest drops for exactly one cycle after a request appears
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= !access;
      readdata    <= access ? next_readdata : readdata;
    end
  end

  // control register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refSel          <= 1'b0;
      bypass          <= 1'b0;
      mult            <= MULT_RESET;
      div             <= DIV_RESET;
      odiv            <= ODIV_RESET;
      deepSleepSelect <= 1'b0;
      rxEn            <= 1'b0;
      txEn            <= 1'b0;
      monSel          <= '0;
    end else if (wrTake) begin
      case (address)
        PLL_CTRL_OFS: begin
          refSel <= writedata[REF_SEL_BIT];
          bypass <= writedata[BYPASS_BIT];
        end
        PLL_FACTOR_OFS: begin
          mult <= writedata[MULT_LSB +: 6];
          div  <= writedata[DIV_LSB +: 6];
          odiv <= writedata[ODIV_LSB +: 2];
        end
        POWER_OFS: begin
          deepSleepSelect <= writedata[DEEP_BIT];
          rxEn            <= writedata[RX_EN_BIT];
          txEn            <= writedata[TX_EN_BIT];
        end
        MON_SEL_OFS: monSel <= writedata[MON_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // per-clock config words; prescale bits beyond the clock's range drop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CLOCKS; i++) begin
        cfgSrc[i] <= SRC_RC;
        cfgPre[i] <= 3'h0;
      end
    end else if (wrTake && cfgHit) begin
      cfgPre[cfgIdx] <= writedata[PRE_LSB +: 3] & pre_mask(cfgIdx);
      if (src_t'(writedata[SRC_LSB +: 2]) == SRC_LOW && cfgIdx != 4'(CAL_IDX)) begin
        cfgSrc[cfgIdx] <= SRC_RC;
      end else begin
        cfgSrc[cfgIdx] <= src_t'(writedata[SRC_LSB +: 2]);
      end
    end
  end

  // monitor: every generated clock and every source can be picked
  assign monVec = {rise[2], rise[0], rise[1], miiTxClock, miiRxClock,
                   randomGenClock, pllPulse, derivedClock};
  assign monNow = (monSel < 5'd23) ? monVec[monSel] : 1'b0;

  // count monitored edges; a write clears, but an edge in the same
  // cycle survives as a count of one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monCount     <= '0;
      monitorClock <= 1'b0;
    end else begin
      monitorClock <= monNow;
      if (wrTake && address == MON_COUNT_OFS) begin
        monCount <= COUNT_WIDTH'(monNow);
      end else if (monNow) begin
        monCount <= monCount + COUNT_WIDTH'(1);
      end
    end
  end

  // output gating by sleep state and mii enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      derivedClock   <= 16'h0000;
      randomGenClock <= 1'b0;
      miiRxClock     <= 1'b0;
      miiTxClock     <= 1'b0;
      cpuClockEn     <= 1'b1;
      busClockEn     <= 1'b1;
      memClockEn     <= 1'b1;
    end else begin
      derivedClock           <= divOut;
      derivedClock[CONV_IDX] <= divOut[CONV_IDX] && !cpuSleep;
      randomGenClock         <= pllPulse && !cpuSleep;
      miiRxClock             <= rise[3] && rxEn;
      miiTxClock             <= rise[4] && txEn;
      cpuClockEn             <= !cpuSleep;
      busClockEn             <= !(cpuSleep && deepSleepSelect);
      memClockEn             <= !(cpuSleep && deepSleepSelect);
    end
  end

  sequence s_request;
    (read || write) && waitrequest;
  endsequence
  a_wait_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    s_request |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  a_sleep_gates_conv: assert property (@(posedge clk) disable iff (!rst_n)
    cpuSleep |=> !derivedClock[CONV_IDX] && !randomGenClock)
    else $error("converter or random clock ran in sleep");
  a_rng_from_pll: assert property (@(posedge clk) disable iff (!rst_n)
    !cpuSleep |=> randomGenClock == $past(pllPulse))
    else $error("random clock differs from pll output");
  a_deep_gates_bus: assert property (@(posedge clk) disable iff (!rst_n)
    cpuSleep && deepSleepSelect |=> !busClockEn && !memClockEn && !cpuClockEn)
    else $error("deep sleep left bus or memory clock on");
  a_light_keeps_bus: assert property (@(posedge clk) disable iff (!rst_n)
    cpuSleep && !deepSleepSelect |=> busClockEn && memClockEn && !cpuClockEn)
    else $error("ordinary sleep gated the wrong clocks");
  a_mii_gate_off: assert property (@(posedge clk) disable iff (!rst_n)
    !rxEn && !txEn |=> !miiRxClock && !miiTxClock)
    else $error("mii clock passed while gated");
  a_low_only_cal: assert property (@(posedge clk) disable iff (!rst_n)
    cfgSrc[0] != SRC_LOW && cfgSrc[15] != SRC_LOW)
    else $error("low-speed source on a non-calendar clock");
  a_fast_pre_limit: assert property (@(posedge clk) disable iff (!rst_n)
    cfgPre[0] <= 3'h3 && cfgPre[3] <= 3'h3)
    else $error("fast clock prescale beyond divide by eight");
endmodule

// ### design/clock_generator_pkg.sv
// constants shared by the clock generator unit and its dividers
// assumes a single 100 MHz system clock and word-wide Avalon-MM access
package clock_generator_pkg;
  // register byte offsets
  localparam logic [7:0] PLL_CTRL_OFS   = 8'h00; // reference select, bypass
  localparam logic [7:0] PLL_FACTOR_OFS = 8'h04; // multiplier, divider, output divider
  localparam logic [7:0] POWER_OFS      = 8'h08; // deep sleep select, mii gates
  localparam logic [7:0] MON_SEL_OFS    = 8'h0c; // monitored clock select
  localparam logic [7:0] MON_COUNT_OFS  = 8'h10; // pulses seen on monitored clock
  localparam logic [7:0] CFG_BASE_OFS   = 8'h40; // first per-clock config word
  // field positions
  localparam int REF_SEL_BIT  = 0;
  localparam int BYPASS_BIT   = 1;
  localparam int MULT_LSB     = 0;
  localparam int DIV_LSB      = 8;
  localparam int ODIV_LSB     = 16;
  localparam int DEEP_BIT     = 0;
  localparam int RX_EN_BIT    = 1;
  localparam int TX_EN_BIT    = 2;
  localparam int SRC_LSB      = 0;
  localparam int PRE_LSB      = 4;
  // reset values
  localparam logic [5:0] MULT_RESET = 6'h01;
  localparam logic [5:0] DIV_RESET  = 6'h01;
  localparam logic [1:0] ODIV_RESET = 2'h0;
  // derived clock count and positions
  localparam int NUM_CLOCKS   = 16;
  localparam int CONV_IDX     = 1;
  localparam int FAST_CLOCKS  = 4;  // system, converter, both serial: 1/1..1/8
  localparam int CAL_IDX      = 14;
  localparam int MON_WIDTH    = 5;
  localparam int COUNT_WIDTH  = 16;
  // source codes, reset code is the rc oscillator
  typedef enum logic [1:0] {SRC_RC, SRC_PLL, SRC_EXT, SRC_LOW} src_t;
  localparam logic [2:0] PRE_FAST_MASK = 3'h3;
  localparam logic [2:0] PRE_SLOW_MASK = 3'h7;
endpackage

// ### design/src_pulse_if.sv
// carries the four source-clock pulses to every derived-clock divider
// assumes all pulses are one clk cycle wide, in the clk domain
`timescale 1ns/100ps
interface src_pulse_if;
  logic [3:0] pulse; // indexed by src_t
  modport drive (output pulse);
  modport take  (input  pulse);
endinterface

// ### design/pll_rate_model.sv
// digital rate model of the pll: out rate = ref rate * m / (n * od)
// assumes refPulse is a one-cycle pulse per reference rising edge
`timescale 1ns/100ps
module pll_rate_model
  import clock_generator_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       refPulse,  // reference edge
  input  wire logic [5:0] mult,      // unsigned, bit 5 msb
  input  wire logic [5:0] div,       // unsigned, bit 5 msb
  input  wire logic [1:0] odiv,      // factor 2**(2*od1+od0)
  input  wire logic       bypass,    // pass the reference straight through
  output logic            pllPulse   // one pulse per output edge
);
  logic [10:0] acc;      // credit accumulator
  logic [10:0] denom;    // n * od, zero n read as one
  logic [10:0] credit;
  logic        emit;

  // od factor is a shift; n of zero would emit on every clk, so it counts as one
  assign denom  = 11'((div == 6'h00 ? 6'h01 : div)) << odiv;
  assign credit = acc + (refPulse ? {5'h00, mult} : 11'h000);
  assign emit   = (credit >= denom);

  // at most one output edge per clk: rates above clk are capped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc      <= 11'h000;
      pllPulse <= 1'b0;
    end else if (bypass) begin
      acc      <= 11'h000;
      pllPulse <= refPulse;
    end else begin
      acc      <= emit ? credit - denom : credit;
      pllPulse <= emit;
    end
  end

  a_bypass_follows: assert property (@(posedge clk) disable iff (!rst_n)
    bypass && $past(bypass) |-> pllPulse == $past(refPulse))
    else $error("bypass output does not follow reference");
  a_no_pulse_zero_m: assert property (@(posedge clk) disable iff (!rst_n)
    !bypass && mult == 6'h00 && acc == 11'h000 |=> !pllPulse)
    else $error("pll output with zero multiplier");
endmodule

// ### design/derived_clock_divider.sv
// one derived clock: source select plus power-of-two prescaler
// assumes source pulses come through src_pulse_if; config may change at any time
`timescale 1ns/100ps
module derived_clock_divider
  import clock_generator_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  src_pulse_if.take  src,
  input  wire src_t  srcSel,   // wanted source
  input  wire logic [2:0] preSel, // wanted prescale exponent
  output logic       outPulse  // one pulse per derived edge
);
  src_t       activeSrc;   // source in use
  logic [2:0] activePre;   // prescale in use
  logic [6:0] cnt;         // source edges in this period
  logic       tick;
  logic       wrap;

  function automatic logic [6:0] period_last(input logic [2:0] e);
    period_last = 7'((8'h01 << e) - 8'h01);
  endfunction

  assign tick = src.pulse[activeSrc];
  assign wrap = tick && (cnt >= period_last(activePre));

  // new settings are adopted only at a period boundary, so no runt
  // period appears; limitation: a dead source delays the switch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      activeSrc <= SRC_RC;
      activePre <= 3'h0;
      cnt       <= 7'h00;
      outPulse  <= 1'b0;
    end else begin
      outPulse <= wrap;
      if (wrap) begin
        cnt       <= 7'h00;
        activeSrc <= srcSel;
        activePre <= preSel;
      end else if (tick) begin
        cnt <= cnt + 7'h01;
      end
    end
  end

  sequence s_no_edge;
    !wrap;
  endsequence
  a_switch_boundary: assert property (@(posedge clk) disable iff (!rst_n)
    s_no_edge |=> $stable(activeSrc) && $stable(activePre))
    else $error("clock setting changed inside a period");
  a_pulse_has_src: assert property (@(posedge clk) disable iff (!rst_n)
    !tick |=> !outPulse)
    else $error("derived edge without a source edge");
  a_div_by_one: assert property (@(posedge clk) disable iff (!rst_n)
    activePre == 3'h0 && tick |=> outPulse)
    else $error("divide by one missed an edge");
endmodule

// ### test/clock_consumer_model.sv
// far-side model: the peripherals that consume the generated edge pulses
// assumes every pulse input is one clk cycle wide and sampled on clk
`timescale 1ns/100ps
module clock_consumer_model
  import clock_generator_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [15:0] derivedClock,
  input  wire logic        randomGenClock,
  input  wire logic        miiRxClock,
  input  wire logic        miiTxClock,
  input  wire logic        monitorClock,
  output int               pulseCount [0:19]
);
  // each consumer counts its edges; counts never clear, the bench takes differences
  // an unknown pulse is not counted, so it shows up as a rate mismatch
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_CLOCKS; i++) begin
      if (derivedClock[i] === 1'b1) pulseCount[i] <= pulseCount[i] + 1;
    end
    if (randomGenClock === 1'b1) pulseCount[16] <= pulseCount[16] + 1;
    if (miiRxClock === 1'b1) pulseCount[17] <= pulseCount[17] + 1;
    if (miiTxClock === 1'b1) pulseCount[18] <= pulseCount[18] + 1;
    if (monitorClock === 1'b1) pulseCount[19] <= pulseCount[19] + 1;
  end
endmodule

// ### test/clock_generator_unit_tb.sv
// self-checking bench for the clock generator unit
// assumes one Avalon answer per access and free-running oscillator pins
`timescale 1ns/100ps
module clock_generator_unit_tb
  import clock_generator_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, cpuSleep = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata;
  logic        waitrequest, randomGenClock, miiRxClock, miiTxClock, monitorClock;
  logic        cpuClockEn, busClockEn, memClockEn;
  logic [15:0] derivedClock;
  logic        rcOscClock = 1'b0, extOscClock = 1'b0, lowSpeedClock = 1'b0;
  logic        miiRxPad = 1'b0, miiTxPad = 1'b0;
  int          pulseCount [0:19];    // consumer counts
  int          srcEdge [0:4];        // rc, ext, low, rx pad, tx pad edges
  int          dp [0:19], ds [0:4];  // differences over one window
  int          errors = 0, cmpCount = 0;
  logic [31:0] shadow [0:63];        // register model, one word each
  // 100 MHz clock and oscillators off the clk grid, so phases drift
  always #5 clk = ~clk;
  always #62.3 rcOscClock <= ~rcOscClock;
  always #24.7 extOscClock <= ~extOscClock;
  always #15258.7 lowSpeedClock <= ~lowSpeedClock;
  always #20.3 miiRxPad <= ~miiRxPad;
  always #20.9 miiTxPad <= ~miiTxPad;
  // source edge counters give the reference for every rate
  always @(posedge rcOscClock) srcEdge[0]++;
  always @(posedge extOscClock) srcEdge[1]++;
  always @(posedge lowSpeedClock) srcEdge[2]++;
  always @(posedge miiRxPad) srcEdge[3]++;
  always @(posedge miiTxPad) srcEdge[4]++;
  clock_generator_unit u_clock_generator_unit (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .extOscClock(extOscClock), .rcOscClock(rcOscClock), .lowSpeedClock(lowSpeedClock),
    .miiRxPad(miiRxPad), .miiTxPad(miiTxPad), .cpuSleep(cpuSleep),
    .derivedClock(derivedClock), .randomGenClock(randomGenClock), .miiRxClock(miiRxClock),
    .miiTxClock(miiTxClock), .cpuClockEn(cpuClockEn), .busClockEn(busClockEn),
    .memClockEn(memClockEn), .monitorClock(monitorClock));
  clock_consumer_model u_clock_consumer_model (
    .clk(clk), .derivedClock(derivedClock), .randomGenClock(randomGenClock),
    .miiRxClock(miiRxClock), .miiTxClock(miiTxClock), .monitorClock(monitorClock),
    .pulseCount(pulseCount));
  // what a write leaves in a register, worked out from the field rules
  function automatic logic [31:0] stored(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    int          i;
    v = 32'h0;
    i = (int'(a) - int'(CFG_BASE_OFS)) / 4;
    if (a == PLL_CTRL_OFS) v = d & 32'h3;
    else if (a == PLL_FACTOR_OFS) v = d & 32'h3_3f3f;
    else if (a == POWER_OFS) v = d & 32'h7;
    else if (a == MON_SEL_OFS) v = d & 32'h1f;
    else if (a >= CFG_BASE_OFS && i < NUM_CLOCKS) begin
      // low-speed source only on the calendar clock, fast clocks stop at /8
      v[1:0] = (d[1:0] == 2'h3 && i != CAL_IDX) ? 2'h0 : d[1:0];
      v[6:4] = (i < FAST_CLOCKS) ? {1'b0, d[5:4]} : d[6:4];
    end
    return v;
  endfunction
  function automatic logic [7:0] cfgA(input int i);
    return CFG_BASE_OFS + 8'(4 * i);
  endfunction
  // the single compare point
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // rates carry two edges of slack for synchroniser delay and window phase
  task automatic near(input string what, input int seen, input int exp);
    check(what, 32'((seen - exp <= 2 && exp - seen <= 2) ? exp : seen), 32'(exp));
  endtask
  // one Avalon access; request held until waitrequest is sampled low
  task automatic access(input logic rd, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    if (n >= 50) errors++;
    read <= 1'b0;
    write <= 1'b0;
    if (!rd) shadow[a[7:2]] = stored(a, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b0, a, d, q);
  endtask
  task automatic rdchk(input logic [7:0] a);
    logic [31:0] q;
    access(1'b1, a, 32'h0, q);
    check("readdata", q, shadow[a[7:2]]);
  endtask
  // settle after a change, then count pulses and source edges over a window
  task automatic measure(input int settle, input int cycles);
    int a [0:19];
    int b [0:4];
    repeat (settle) @(posedge clk);
    a = pulseCount;
    b = srcEdge;
    repeat (cycles) @(posedge clk);
    foreach (dp[i]) dp[i] = pulseCount[i] - a[i];
    foreach (ds[i]) ds[i] = srcEdge[i] - b[i];
  endtask
  task automatic final_report();
    if (errors == 0 && cmpCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang guard, well beyond the planned run of some 72k cycles
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    final_report();
  end
  // main sequence
  initial begin
    int m, n, od, rf, re, pll;
    logic [31:0] q;
    void'($urandom(32'hda0634e0));
    foreach (shadow[i]) shadow[i] = 32'h0;
    shadow[PLL_FACTOR_OFS[7:2]] = 32'(MULT_RESET) | (32'(DIV_RESET) << DIV_LSB);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset contents, an unmapped word ignores writes
    for (int i = 0; i < NUM_CLOCKS; i++) rdchk(cfgA(i));
    rdchk(PLL_CTRL_OFS);
    rdchk(PLL_FACTOR_OFS);
    rdchk(POWER_OFS);
    wr(8'h3c, $urandom);
    rdchk(8'h3c);
    check("cpuClockEn", {31'h0, cpuClockEn}, 32'h1);
    // slow clocks: every exponent, each on its own timer or pwm clock
    for (int e = 0; e < 8; e++) begin
      wr(cfgA(4 + e), 32'(e) << PRE_LSB);
      rdchk(cfgA(4 + e));
      measure(200 + (20 << e), 400 + (60 << e));
      near("slowRate", dp[4 + e], ds[0] >> e);
    end
    // clocks never written still run from rc at divide by one
    near("resetRate", dp[12], ds[0]);
    near("resetRate", dp[13], ds[0]);
    near("resetRate", dp[15], ds[0]);
    // fast clocks: exponent 7 is cut to 3, sources alternate rc and external
    for (int i = 0; i < FAST_CLOCKS; i++) begin
      wr(cfgA(i), (32'h7 << PRE_LSB) | (i[0] ? 32'(SRC_EXT) : 32'(SRC_RC)));
      rdchk(cfgA(i));
      measure(400, 1000);
      near("fastRate", dp[i], ds[i[0]] >> 3);
    end
    // low-speed source refused off the calendar clock, accepted on it
    wr(cfgA(5), 32'h3);
    rdchk(cfgA(5));
    wr(cfgA(CAL_IDX), 32'(SRC_LOW));
    rdchk(cfgA(CAL_IDX));
    measure(200, 20000);
    near("calendarRate", dp[CAL_IDX], ds[2]);
    // pll: random factors and reference, bypass last
    wr(cfgA(6), (32'h1 << PRE_LSB) | 32'(SRC_PLL));
    for (int k = 0; k < 4; k++) begin
      // n at or above m keeps the pll at most one pulse per reference edge,
      // so window phase stays inside the slack; pass 0 runs a zero multiplier
      m = (k == 0) ? 0 : 1 + $urandom % 4;
      n = ((m == 0) ? 1 : m) + $urandom % 4;
      od = $urandom % 4;
      rf = $urandom % 2;
      wr(PLL_CTRL_OFS, (32'(k == 3) << BYPASS_BIT) | (32'(rf) << REF_SEL_BIT));
      wr(PLL_FACTOR_OFS, 32'(m) | (32'(n) << DIV_LSB) | (32'(od) << ODIV_LSB));
      rdchk(PLL_FACTOR_OFS);
      measure(300, 3000);
      re = rf ? ds[1] : ds[0];
      pll = (k == 3) ? re : re * m / (n << od);
      near("pllRate", dp[16], pll);
      near("pllDerived", dp[6], pll / 2);
    end
    // ordinary sleep stops converter and random clocks and the cpu only
    @(posedge clk);
    cpuSleep <= 1'b1;
    measure(10, 1000);
    check("randomSleep", 32'(dp[16]), 32'h0);
    check("converterSleep", 32'(dp[CONV_IDX]), 32'h0);
    check("cpuClockEn", {31'h0, cpuClockEn}, 32'h0);
    check("busClockEn", {31'h0, busClockEn}, 32'h1);
    wr(POWER_OFS, 32'h1 << DEEP_BIT);
    repeat (3) @(posedge clk);
    check("busDeep", {31'h0, busClockEn}, 32'h0);
    check("memDeep", {31'h0, memClockEn}, 32'h0);
    cpuSleep <= 1'b0;
    measure(10, 1000);
    check("memWake", {31'h0, memClockEn}, 32'h1);
    near("converterWake", dp[CONV_IDX], ds[1] >> 3);
    // mii gating, each direction on its own
    wr(POWER_OFS, 32'h1 << RX_EN_BIT);
    measure(10, 1000);
    near("rxOn", dp[17], ds[3]);
    check("txOff", 32'(dp[18]), 32'h0);
    wr(POWER_OFS, 32'h1 << TX_EN_BIT);
    measure(10, 1000);
    near("txOn", dp[18], ds[4]);
    check("rxOff", 32'(dp[17]), 32'h0);
    wr(POWER_OFS, (32'h1 << RX_EN_BIT) | (32'h1 << TX_EN_BIT));
    // monitor rc, external and mii receive; count cleared by a write
    for (int s = 0; s < 3; s++) begin
      wr(MON_SEL_OFS, (s == 2) ? 32'd18 : 32'(20 + s));
      rdchk(MON_SEL_OFS);
      wr(MON_COUNT_OFS, 32'h0);
      measure(0, 1000);
      access(1'b1, MON_COUNT_OFS, 32'h0, q);
      near("monitorCount", int'(q[15:0]), ds[(s == 2) ? 3 : s]);
      near("monitorPulse", dp[19], ds[(s == 2) ? 3 : s]);
    end
    final_report();
  end
endmodule
